// ==== shared/asg_consts.svh ====
// offsets, field positions, reset values of the trigger gate
`ifndef ASG_CONSTS_SVH
`define ASG_CONSTS_SVH
`define ASG_OFS_CTRL 8'h00
`define ASG_OFS_FRAMES 8'h04
`define ASG_OFS_CMD 8'h08
`define ASG_OFS_STATUS 8'h0C
`define ASG_CTRL_GATE 0
`define ASG_CTRL_ORIGIN 1
`define ASG_CTRL_EDGE 2
`define ASG_CTRL_TARGET 3
`define ASG_CTRL_RUNMODE 4
`define ASG_CMD_TRIG 0
`define ASG_CMD_BEGIN 1
`define ASG_CMD_END 2
`define ASG_CTRL_RST 5'h00
`define ASG_FRAMES_RST 8'h01
`define ASG_FRAMES_MIN 8'h01
`define ASG_FRAMES_MAX 8'hFF
`endif

// ==== shared/asg_pkg.sv ====
// types shared by the trigger gate modules
package asg_pkg;
	typedef enum logic [2:0] {
		ASG_IDLE = 3'h1,
		ASG_WAIT_ACQ = 3'h2,
		ASG_WAIT_FRAME = 3'h4
	} asg_state_t;
endpackage

// ==== verilog/asg_edge_detect.sv ====
// pin synchroniser and selectable edge detector
`timescale 1ns/1ps
`default_nettype none
module asg_edge_detect (
	input wire logic clk,
	input wire logic nrst,
	input wire logic pin,
	input wire logic falling_sel,
	output logic pulse
);
	logic sync1; // first stage, read only by sync2
	logic sync2; // safe copy of the pin
	logic prev; // last safe value
	logic next_pulse;

	// edge from the settled stages only
	always_comb begin
		if (falling_sel) begin
			next_pulse = prev & ~sync2; // see R9
		end else begin
			next_pulse = ~prev & sync2; // see R9
		end
	end

	// two flops before any logic looks at the pin
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			prev <= 1'b0;
			pulse <= 1'b0;
		end else begin
			sync1 <= pin;
			sync2 <= sync1;
			prev <= sync2;
			pulse <= next_pulse; // see R15
		end
	end

	property p_one_cycle;
		@(posedge clk) disable iff (!nrst)
		pulse |=> !pulse;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("edge pulse stuck"); // see R15

	// a rising pulse leaves the stage high, a falling one low
	property p_edge_dir;
		@(posedge clk) disable iff (!nrst)
		pulse |-> prev == !$past(falling_sel);
	endproperty
	a_edge_dir: assert property (p_edge_dir) else $error("pulse on wrong edge"); // see R9
endmodule
`default_nettype wire

// ==== verilog/asg_frame_counter.sv ====
// counts accepted frame starts against the programmed limit
`timescale 1ns/1ps
`default_nettype none
module asg_frame_counter #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic clear,
	input wire logic inc,
	input wire logic [W-1:0] limit,
	output logic [W-1:0] count,
	output logic done
);
	logic [W-1:0] next_count;

	initial begin
		if (W < 1 || W > 16) $error("counter width out of range");
	end

	// done fires on the accept that reaches the limit
	assign done = inc && (count + 1'b1 == limit); // see R6

	// clear has priority; no wrap since done leaves the state
	always_comb begin
		if (clear) begin
			next_count = '0; // see R14
		end else if (inc) begin
			next_count = count + 1'b1;
		end else begin
			next_count = count;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
endmodule
`default_nettype wire

// ==== verilog/asg_trigger_gate.sv ====
// acquisition start trigger gate with apb registers
// Contract
// R1: frame count programmable from 1 to 255
// R2: host programs count when enabling gating
// R3: gating on starts in wait-for-acquisition
// R4: frame triggers ignored while waiting acquisition
// R5: acquisition trigger moves to wait-for-frame
// R6: count reached returns to wait-for-acquisition
// R7: host trigger command gives one acquisition trigger
// R8: line 1 pin is the hardware source
// R9: rising or falling edge as selected
// R10: host uses continuous mode when gating
// R11: host begins before triggers, ends after
// R12: gating off makes acquisition start internally
// R13: acquisition triggers elsewhere are discarded
// R14: counter cleared on entering wait-for-frame (code clears it only on entry from wait-for-acquisition, not from idle)
// R15: pin edge gives one-cycle pulse
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "asg_consts.svh"
module asg_trigger_gate #(
	parameter int CW = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_acq_start_signal,
	input wire logic frame_trigger_in,
	output logic frame_start_out,
	output asg_pkg::asg_state_t acq_state,
	output logic capture_running
);
	import asg_pkg::*;

	initial begin
		if (CW != 8) $error("frame count width must be 8");
	end

	////////////////////////////////////////////////////////////////////
	// register bus

	logic [4:0] ctrl; // gate, origin, edge, target, run mode
	logic [4:0] next_ctrl;
	logic [CW-1:0] frames_per_acquisition; // limit for one acquisition
	logic [CW-1:0] next_frames;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic wr; // write taken this edge
	logic setup; // first cycle of a transfer
	logic mapped; // address hits a register
	logic [CW-1:0] count; // frames accepted so far
	logic count_done; // last frame accepted
	logic trigger_gating_enable;
	logic trigger_origin_select; // 0 software, 1 line 1
	logic trigger_edge_select; // 0 rising, 1 falling
	logic trigger_target_select; // 0 frame start, 1 acq start
	logic capture_run_mode; // 1 continuous
	logic host_trigger_command;
	logic capture_begin_command;
	logic capture_end_command;

	assign trigger_gating_enable = ctrl[`ASG_CTRL_GATE];
	assign trigger_origin_select = ctrl[`ASG_CTRL_ORIGIN];
	assign trigger_edge_select = ctrl[`ASG_CTRL_EDGE];
	assign trigger_target_select = ctrl[`ASG_CTRL_TARGET];
	assign capture_run_mode = ctrl[`ASG_CTRL_RUNMODE];

	// zero wait states: access phase always completes at once
	assign pready = 1'b1;
	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign mapped = (paddr == `ASG_OFS_CTRL) || (paddr == `ASG_OFS_FRAMES) ||
		(paddr == `ASG_OFS_CMD) || (paddr == `ASG_OFS_STATUS);

	// command bits are pulses, never stored
	assign host_trigger_command = wr && paddr == `ASG_OFS_CMD && pwdata[`ASG_CMD_TRIG];
	assign capture_begin_command = wr && paddr == `ASG_OFS_CMD && pwdata[`ASG_CMD_BEGIN];
	assign capture_end_command = wr && paddr == `ASG_OFS_CMD && pwdata[`ASG_CMD_END];

	// register writes taken in the access cycle, read data captured in the setup cycle
	always_comb begin
		next_ctrl = ctrl;
		next_frames = frames_per_acquisition;
		next_prdata = prdata;
		next_pslverr = pslverr;
		if (wr && paddr == `ASG_OFS_CTRL) begin
			next_ctrl = pwdata[4:0];
		end
		// zero is not a legal count, so such a write is dropped
		if (wr && paddr == `ASG_OFS_FRAMES && pwdata[CW-1:0] >= `ASG_FRAMES_MIN) begin
			next_frames = pwdata[CW-1:0]; // see R1
		end
		if (setup) begin
			next_pslverr = !mapped;
			next_prdata = 32'h0000_0000;
			if (!pwrite) begin
				unique case (paddr)
					`ASG_OFS_CTRL: begin
						next_prdata = {27'h0, ctrl};
					end
					`ASG_OFS_FRAMES: begin
						next_prdata = {24'h0, frames_per_acquisition};
					end
					`ASG_OFS_STATUS: begin
						next_prdata = {15'h0, capture_running, count, 5'h0, acq_state};
					end
					default: begin
						next_prdata = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl <= `ASG_CTRL_RST;
			frames_per_acquisition <= `ASG_FRAMES_RST;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			frames_per_acquisition <= next_frames;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	////////////////////////////////////////////////////////////////////
	// trigger sources

	logic pin_edge; // qualified edge on line 1
	logic acq_trigger; // one acquisition start trigger
	logic next_running;
	asg_state_t next_state;
	logic enter_frame; // wait-acq to wait-frame this cycle
	logic frame_accept; // frame trigger honoured
	logic next_frame_out;

	asg_edge_detect u_edge (
		.clk(clk),
		.nrst(nrst),
		.pin(external_acq_start_signal),
		.falling_sel(trigger_edge_select),
		.pulse(pin_edge)
	);

	// one source at a time; the other is ignored
	always_comb begin
		if (trigger_origin_select) begin
			acq_trigger = pin_edge; // see R8
		end else begin
			acq_trigger = host_trigger_command && trigger_target_select; // see R7
		end
	end

	////////////////////////////////////////////////////////////////////
	// acquisition status machine

	// any way out of wait-acq into wait-frame restarts the count
	assign enter_frame = acq_state == ASG_WAIT_ACQ && next_state == ASG_WAIT_FRAME; // see R5, R14
	// only the wait-frame state lets frame triggers through
	assign frame_accept = acq_state == ASG_WAIT_FRAME && frame_trigger_in; // see R4

	asg_frame_counter #(
		.W(CW)
	) u_count (
		.clk(clk),
		.nrst(nrst),
		.clear(enter_frame),
		.inc(frame_accept && trigger_gating_enable),
		.limit(frames_per_acquisition),
		.count(count),
		.done(count_done)
	);

	// begin wins over end in the same cycle
	always_comb begin
		next_running = capture_running;
		if (capture_end_command) begin
			next_running = 1'b0;
		end
		if (capture_begin_command) begin
			next_running = 1'b1;
		end
	end

	// status transitions; stop returns to idle unless begin comes in the same cycle
	always_comb begin
		next_state = acq_state;
		next_frame_out = frame_accept;
		unique case (acq_state)
			ASG_IDLE: begin
				if (next_running) begin
					// gated start waits; ungated starts itself
					next_state = trigger_gating_enable ? ASG_WAIT_ACQ : ASG_WAIT_FRAME; // see R3
				end
			end
			ASG_WAIT_ACQ: begin
				if (!trigger_gating_enable) begin
					next_state = ASG_WAIT_FRAME; // see R12
				end else if (acq_trigger) begin
					next_state = ASG_WAIT_FRAME; // see R5
				end
			end
			ASG_WAIT_FRAME: begin
				// acquisition triggers here fall on the floor
				if (count_done) begin
					next_state = ASG_WAIT_ACQ; // see R6, R13
				end
			end
			default: begin
				next_state = ASG_IDLE;
			end
		endcase
		if (!next_running) begin
			next_state = ASG_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			acq_state <= ASG_IDLE;
			capture_running <= 1'b0;
			frame_start_out <= 1'b0;
		end else begin
			acq_state <= next_state;
			capture_running <= next_running;
			frame_start_out <= next_frame_out;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks

	sequence s_accept_last;
		acq_state == ASG_WAIT_FRAME && frame_trigger_in && trigger_gating_enable
			&& count + 1'b1 == frames_per_acquisition;
	endsequence

	property p_frames_legal;
		@(posedge clk) disable iff (!nrst)
		frames_per_acquisition != '0;
	endproperty
	a_frames_legal: assert property (p_frames_legal) else $error("frame count illegal"); // see R1

	property p_frame_pass;
		@(posedge clk) disable iff (!nrst)
		acq_state == ASG_WAIT_FRAME && frame_trigger_in |=> frame_start_out;
	endproperty
	a_frame_pass: assert property (p_frame_pass) else $error("frame trigger dropped"); // see R5

	property p_gate_waits;
		@(posedge clk) disable iff (!nrst)
		acq_state == ASG_IDLE && capture_begin_command && trigger_gating_enable
			|=> acq_state == ASG_WAIT_ACQ;
	endproperty
	a_gate_waits: assert property (p_gate_waits) else $error("no wait after begin"); // see R3

	property p_no_frame;
		@(posedge clk) disable iff (!nrst)
		acq_state != ASG_WAIT_FRAME |=> !frame_start_out;
	endproperty
	a_no_frame: assert property (p_no_frame) else $error("frame outside wait-frame"); // see R4

	property p_acq_enter;
		@(posedge clk) disable iff (!nrst)
		acq_state == ASG_WAIT_ACQ && acq_trigger && !capture_end_command
			|=> acq_state == ASG_WAIT_FRAME && count == 8'h00;
	endproperty
	a_acq_enter: assert property (p_acq_enter) else $error("trigger not taken"); // see R5, R14

	property p_last_frame;
		@(posedge clk) disable iff (!nrst)
		s_accept_last and !capture_end_command |=> acq_state == ASG_WAIT_ACQ && frame_start_out;
	endproperty
	a_last_frame: assert property (p_last_frame) else $error("no return after limit"); // see R6

	property p_soft_trig;
		@(posedge clk) disable iff (!nrst)
		acq_state == ASG_WAIT_ACQ && !trigger_origin_select && trigger_target_select
			&& host_trigger_command && !capture_end_command |=> acq_state == ASG_WAIT_FRAME;
	endproperty
	a_soft_trig: assert property (p_soft_trig) else $error("host trigger lost"); // see R7

	property p_pin_trig;
		@(posedge clk) disable iff (!nrst)
		acq_state == ASG_WAIT_ACQ && trigger_origin_select && pin_edge
			&& !capture_end_command |=> acq_state == ASG_WAIT_FRAME;
	endproperty
	a_pin_trig: assert property (p_pin_trig) else $error("pin trigger lost"); // see R8, R9

	property p_ungated;
		@(posedge clk) disable iff (!nrst)
		capture_running && !trigger_gating_enable && !capture_end_command
			|=> acq_state == ASG_WAIT_FRAME;
	endproperty
	a_ungated: assert property (p_ungated) else $error("ungated not running"); // see R12

	property p_discard;
		@(posedge clk) disable iff (!nrst)
		acq_state == ASG_WAIT_FRAME && acq_trigger && !count_done && capture_running
			&& !capture_end_command |=> acq_state == ASG_WAIT_FRAME
			&& count == $past(count) + {7'h00, $past(frame_trigger_in && trigger_gating_enable)};
	endproperty
	a_discard: assert property (p_discard) else $error("stray trigger acted"); // see R13
endmodule
`default_nettype wire

// ==== tb/asg_trig_source.sv ====
// far-side model: external trigger line and frame trigger source
`timescale 1ns/1ps
`default_nettype none
module asg_trig_source (
	output logic pin,
	output logic frame_trig,
	input wire logic clk
);
	// the line holds its level between edges, as a real driver does
	initial begin
		pin = 1'b0;
		frame_trig = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// one level change on line 1, launched just after an edge
	task set_pin(input logic v);
		@(posedge clk);
		pin <= v;
	endtask
	// single-cycle frame start request from same-clock logic
	task frame_pulse();
		@(posedge clk);
		frame_trig <= 1'b1;
		@(posedge clk);
		frame_trig <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== tb/asg_trigger_gate_tb_top.sv ====
// self-checking bench for the acquisition start trigger gate
`timescale 1ns/1ps
`default_nettype none
`include "asg_consts.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
	$display("mismatch %s exp %0h got %0h", nm, e, g); end end
module asg_trigger_gate_tb_top;
	import asg_pkg::*;
	logic clk = 1'b0; // 25 MHz
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pin;
	logic ft;
	logic frame_start_out;
	asg_state_t acq_state;
	logic capture_running;
	logic [31:0] rdata; // read data taken at the access edge
	logic rerr;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	////////////////////////////////////////////////////////////////
	asg_trigger_gate asg_trigger_gate_inst (.clk(clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_acq_start_signal(pin), .frame_trigger_in(ft),
		.frame_start_out(frame_start_out), .acq_state(acq_state),
		.capture_running(capture_running));
	asg_trig_source asg_trig_source_inst (.pin(pin), .frame_trig(ft), .clk(clk));
	// clock and hang guard
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////
	// one apb transfer; request held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// access phase lasts until pready is seen high; if it never is, only the hang guard ends it
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// let a transition land (pin path needs 4 edges), then compare state
	task st(input asg_state_t e);
		repeat (6) @(posedge clk);
		#1;
		`CHK("acq_state", e, acq_state)
	endtask
	task fpulse(input logic e);
		asg_trig_source_inst.frame_pulse();
		#1;
		`CHK("frame_start_out", e, frame_start_out)
	endtask
	////////////////////////////////////////////////////////////////
	task t_reset();
		apb(1'b0, `ASG_OFS_FRAMES, 32'h0);
		`CHK("frames_rst", 8'h01, rdata[7:0])
		apb(1'b0, `ASG_OFS_CTRL, 32'h0);
		`CHK("ctrl_rst", 5'h00, rdata[4:0])
		apb(1'b0, 8'h10, 32'h0);
		`CHK("unmapped", 1'b1, rerr)
		`CHK("pready", 1'b1, pready)
		apb(1'b1, `ASG_OFS_FRAMES, 32'hFF);
		apb(1'b1, `ASG_OFS_FRAMES, 32'h0);
		apb(1'b0, `ASG_OFS_FRAMES, 32'h0);
		`CHK("frames_max", 8'hFF, rdata[7:0])
		$display("test reset done");
	endtask
	// software acquisition start, two frames per acquisition
	task t_soft();
		apb(1'b1, `ASG_OFS_FRAMES, 32'h2);
		apb(1'b1, `ASG_OFS_CTRL, 32'h11);
		apb(1'b1, `ASG_OFS_CMD, 32'h2);
		st(ASG_WAIT_ACQ);
		apb(1'b1, `ASG_OFS_CMD, 32'h1);
		st(ASG_WAIT_ACQ);
		apb(1'b1, `ASG_OFS_CTRL, 32'h19);
		fpulse(1'b0);
		apb(1'b1, `ASG_OFS_CMD, 32'h1);
		st(ASG_WAIT_FRAME);
		apb(1'b1, `ASG_OFS_CMD, 32'h1);
		st(ASG_WAIT_FRAME);
		fpulse(1'b1);
		`CHK("state_mid", ASG_WAIT_FRAME, acq_state)
		fpulse(1'b1);
		`CHK("state_back", ASG_WAIT_ACQ, acq_state)
		apb(1'b1, `ASG_OFS_CMD, 32'h1);
		st(ASG_WAIT_FRAME);
		apb(1'b0, `ASG_OFS_STATUS, 32'h0);
		`CHK("count_clr", 8'h00, rdata[15:8])
		apb(1'b1, `ASG_OFS_CMD, 32'h4);
		st(ASG_IDLE);
		`CHK("running", 1'b0, capture_running)
		$display("test software trigger done");
	endtask
	// line 1 source, both edge choices, wrong edge first
	task t_pin();
		logic v;
		for (int e = 0; e < 2; e++) begin
			v = e[0];
			asg_trig_source_inst.set_pin(!v);
			apb(1'b1, `ASG_OFS_FRAMES, 32'h1);
			apb(1'b1, `ASG_OFS_CTRL, v ? 32'h1F : 32'h1B);
			apb(1'b1, `ASG_OFS_CMD, 32'h2);
			st(ASG_WAIT_ACQ);
			asg_trig_source_inst.set_pin(v);
			st(ASG_WAIT_ACQ);
			asg_trig_source_inst.set_pin(!v);
			st(ASG_WAIT_FRAME);
			fpulse(1'b1);
			`CHK("one_frame", ASG_WAIT_ACQ, acq_state)
			apb(1'b1, `ASG_OFS_CMD, 32'h4);
			st(ASG_IDLE);
		end
		$display("test line trigger done");
	endtask
	// gating off: begin alone opens frames, no frame limit
	task t_off();
		apb(1'b1, `ASG_OFS_CTRL, 32'h10);
		apb(1'b1, `ASG_OFS_CMD, 32'h2);
		st(ASG_WAIT_FRAME);
		repeat (3) fpulse(1'b1);
		apb(1'b1, `ASG_OFS_CMD, 32'h4);
		st(ASG_IDLE);
		apb(1'b1, `ASG_OFS_CTRL, 32'h19);
		apb(1'b1, `ASG_OFS_CMD, 32'h2);
		st(ASG_WAIT_ACQ);
		apb(1'b1, `ASG_OFS_CTRL, 32'h10);
		st(ASG_WAIT_FRAME);
		apb(1'b0, `ASG_OFS_STATUS, 32'h0);
		`CHK("count_ungated", 8'h00, rdata[15:8])
		`CHK("status_state", 3'h4, rdata[2:0])
		apb(1'b1, `ASG_OFS_CMD, 32'h4);
		st(ASG_IDLE);
		$display("test gating off done");
	endtask
	////////////////////////////////////////////////////////////////
	task tally_and_finish();
		$display("counts compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_soft();
		t_pin();
		t_off();
		tally_and_finish();
	end
endmodule
`default_nettype wire
